// [ssi_controller_end.sv]
// Controller end of the serial position link: makes clock bursts, reads and checks words.
// Assumes the encoder timeout exceeds one bit period; the divider sets the bit rate.
`timescale 1ns/10ps
module ssi_controller_end #(
	parameter int POS_W = ssi_pkg::POS_W,
	parameter int HALF_CYCLES = ssi_pkg::HALF_CYCLES,
	parameter int PAUSE_CYCLES = ssi_pkg::PAUSE_CYCLES,
	parameter int GUARD_CYCLES = ssi_pkg::GUARD_CYCLES,
	parameter int WORDS = ssi_pkg::REPEAT_WORDS
) (
	// System clock, reset and enable.
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	// Link to the encoder.
	ssi_link_if.controller link,
	// Request handshake.
	input wire logic start,
	output logic ready,
	// Received position, binary.
	output logic [POS_W-1:0] word,
	output logic word_valid,
	output logic mismatch
);

	typedef enum {ST_IDLE, ST_LOW, ST_HIGH, ST_PAUSE} ctl_state_t;

	localparam int TW = $clog2(PAUSE_CYCLES + HALF_CYCLES + 1);
	localparam int BW = $clog2(POS_W + 2);
	localparam int WW = $clog2(WORDS + 1);
	localparam logic [TW-1:0] HALF_LD = TW'(HALF_CYCLES - 1);
	localparam logic [TW-1:0] PAUSE_LD = TW'(PAUSE_CYCLES - 1);
	localparam logic [TW-1:0] GUARD_END = TW'(PAUSE_CYCLES - 1 - GUARD_CYCLES);
	localparam logic [BW-1:0] BIT_LAST = BW'(POS_W);
	localparam logic [BW-1:0] BIT_GAP = BW'(POS_W + 1);
	localparam logic [BW-1:0] BIT_ONE = BW'(1);
	localparam logic [WW-1:0] WORD_LAST = WW'(WORDS);
	localparam logic [WW-1:0] WORD_ONE = WW'(1);
	localparam logic [TW-1:0] TM_ONE = TW'(1);

	ctl_state_t state_r;
	ctl_state_t state_nxt;
	logic d1_r;
	logic d2_r;
	logic sclk_r;
	logic sclk_nxt;
	logic [TW-1:0] tm_r;
	logic [TW-1:0] tm_nxt;
	logic [BW-1:0] bit_r;
	logic [BW-1:0] bit_nxt;
	logic [WW-1:0] wrd_r;
	logic [WW-1:0] wrd_nxt;
	logic [POS_W-1:0] sh_r;
	logic [POS_W-1:0] sh_nxt;
	logic [POS_W-1:0] first_r;
	logic [POS_W-1:0] first_nxt;
	logic [POS_W-1:0] word_r;
	logic [POS_W-1:0] word_nxt;
	logic valid_r;
	logic valid_nxt;
	logic mism_r;
	logic mism_nxt;
	logic [POS_W-1:0] gray_in;
	logic [POS_W-1:0] bin_in;

	// Word as it stands with the bit sampled at this falling edge.
	assign gray_in = {sh_r[POS_W-2:0], d2_r};

	// Gray to binary: each bit is the parity of itself and all bits above it.
	for (genvar i = 0; i < POS_W; i++)
	begin : g_bin
		assign bin_in[i] = ^gray_in[POS_W-1:i];
	end

	// Burst sequencer. A word takes one pulse per bit plus a gap pulse; the gap pulse
	// shows the low tail and, when another pulse follows in time, asks for a repeat.
	always_comb
	begin
		state_nxt = state_r;
		sclk_nxt = sclk_r;
		tm_nxt = tm_r;
		bit_nxt = bit_r;
		wrd_nxt = wrd_r;
		sh_nxt = sh_r;
		first_nxt = first_r;
		word_nxt = word_r;
		valid_nxt = 1'b0;
		mism_nxt = mism_r;
		case (state_r)
			ST_IDLE:
			begin
				if (start && d2_r) // see [R6]
				begin
					state_nxt = ST_LOW;
					sclk_nxt = 1'b0;
					tm_nxt = HALF_LD; // see [R8] [R14]
					bit_nxt = '0;
					wrd_nxt = '0;
					mism_nxt = 1'b0;
				end
			end
			ST_LOW:
			begin
				if (tm_r == '0)
				begin
					state_nxt = ST_HIGH;
					sclk_nxt = 1'b1;
					tm_nxt = HALF_LD;
					bit_nxt = (bit_r == BIT_GAP) ? BIT_ONE : bit_r + BIT_ONE;
				end
				else
				begin
					tm_nxt = tm_r - TM_ONE;
				end
			end
			ST_HIGH:
			begin
				if (tm_r == '0)
				begin
					state_nxt = ST_LOW;
					sclk_nxt = 1'b0;
					tm_nxt = HALF_LD;
					if (bit_r != BIT_GAP)
					begin
						sh_nxt = gray_in;
					end
					if (bit_r == BIT_LAST) // see [R9]
					begin
						word_nxt = bin_in;
						valid_nxt = 1'b1;
						wrd_nxt = wrd_r + WORD_ONE;
						if (wrd_r == '0)
						begin
							first_nxt = gray_in;
						end
						else if (gray_in != first_r)
						begin
							mism_nxt = 1'b1; // see [R12]
						end
					end
					else if (bit_r == BIT_GAP && wrd_r == WORD_LAST)
					begin
						state_nxt = ST_PAUSE;
						sclk_nxt = 1'b1; // see [R1]
						tm_nxt = PAUSE_LD;
					end
				end
				else
				begin
					tm_nxt = tm_r - TM_ONE;
				end
			end
			ST_PAUSE:
			begin
				if (tm_r == '0 || (d2_r && tm_r <= GUARD_END))
				begin
					state_nxt = ST_IDLE; // see [R6]
				end
				else
				begin
					tm_nxt = tm_r - TM_ONE;
				end
			end
			default:
			begin
				state_nxt = ST_IDLE;
				sclk_nxt = 1'b1;
			end
		endcase
	end

	// Registers; the data pin passes two flip-flops before use.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_r <= ST_IDLE;
			d1_r <= 1'b0;
			d2_r <= 1'b0;
			sclk_r <= ssi_pkg::LINE_IDLE;
			tm_r <= '0;
			bit_r <= '0;
			wrd_r <= '0;
			sh_r <= '0;
			first_r <= '0;
			word_r <= '0;
			valid_r <= 1'b0;
			mism_r <= 1'b0;
		end
		else if (ce)
		begin
			state_r <= state_nxt;
			d1_r <= link.sdata;
			d2_r <= d1_r;
			sclk_r <= sclk_nxt;
			tm_r <= tm_nxt;
			bit_r <= bit_nxt;
			wrd_r <= wrd_nxt;
			sh_r <= sh_nxt;
			first_r <= first_nxt;
			word_r <= word_nxt;
			valid_r <= valid_nxt;
			mism_r <= mism_nxt;
		end
	end

	// Outputs; ready is a handshake term and may be combinational.
	assign link.sclk = sclk_r;
	assign ready = (state_r == ST_IDLE) && d2_r;
	assign word = word_r;
	assign word_valid = valid_r;
	assign mismatch = mism_r;

endmodule : ssi_controller_end

// [ssi_pkg.sv]
// Shared constants for the synchronous serial position link: word layout and timing.
// Assumes a 20 MHz system clock on both ends and a controller that makes the bit clock.
// Operation
// [R1] Clock and data lines rest high when idle.
// [R2] First clock fall captures the current position.
// [R3] First clock rise presents the most significant bit.
// [R4] Each later rise presents the next lower bit.
// [R5] After the last bit, data low until timeout.
// [R6] Controller waits for data high or pause.
// [R7] Timeout restarts at each falling clock edge.
// [R8] Controller clock period stays below the timeout.
// [R9] Each word holds 24 bits, 12 plus 12.
// [R10] Unbroken clocking repeats the captured word.
// [R11] Pulse after the timeout brings a fresh word.
// [R12] Controller compares repeated copies to find errors.
// [R13] Position is sent Gray coded, rising clockwise.
// [R14] Controller bit rate between 0.1 and 2 Mbit/s.
package ssi_pkg;

	// Word layout: multiturn count in the upper half, angle in the lower half.
	localparam int ST_W = 12;
	localparam int MT_W = 12;
	localparam int POS_W = ST_W + MT_W;

	// System clock period.
	localparam int CLK_PERIOD_NS = 50;

	// Monoflop timeout of the encoder; a least time, so it rounds up.
	localparam int MONO_TIME_NS = 20000;
	localparam int MONO_CYCLES = (MONO_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Half period of the controller bit clock, 500 ns gives 1 Mbit/s.
	localparam int HALF_TIME_NS = 500;
	localparam int HALF_CYCLES = (HALF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Clock pause of the controller after a burst; a longest time, cut short once data is high.
	localparam int PAUSE_TIME_NS = 40000;
	localparam int PAUSE_CYCLES = (PAUSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Cycles the controller ignores the data line after a burst, covering its synchroniser.
	localparam int GUARD_CYCLES = 4;

	// Copies of the word read per burst by the controller.
	localparam int REPEAT_WORDS = 2;

	// Idle level of both lines.
	localparam logic LINE_IDLE = 1'b1;

endpackage : ssi_pkg

// [ssi_link_if.sv]
// The two wires of the serial link: bit clock from the controller, data from the encoder.
// Assumes point-to-point use; line receivers and drivers sit outside.
`timescale 1ns/10ps
interface ssi_link_if;

	// Bit clock, made by the controller.
	logic sclk;
	// Serial data, made by the encoder.
	logic sdata;

	// Encoder end.
	modport encoder (
		input sclk,
		output sdata
	);

	// Controller end.
	modport controller (
		output sclk,
		input sdata
	);

endinterface : ssi_link_if

// [ssi_encoder_end.sv]
// Encoder end of the serial position link: monoflop, word snapshot and shift register.
// Assumes the controller clock is slower than 2.5 Mbit/s so the snapshot settles in time.
`timescale 1ns/10ps
module ssi_encoder_end #(
	parameter int POS_W = ssi_pkg::POS_W,
	parameter int MONO_CYCLES = ssi_pkg::MONO_CYCLES
) (
	// System clock, reset and enable.
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	// Link to the controller.
	ssi_link_if.encoder link,
	// Binary position from the sensing logic, on clk, counting up clockwise.
	input wire logic [POS_W-1:0] pos,
	// Transfer in progress.
	output logic busy
);

	localparam int CW = $clog2(MONO_CYCLES + 1);
	localparam int BW = $clog2(POS_W + 2);
	localparam logic [CW-1:0] MONO_LD = CW'(MONO_CYCLES);
	localparam logic [CW-1:0] MONO_ONE = CW'(1);
	localparam logic [BW-1:0] BIT_LAST = BW'(POS_W);
	localparam logic [BW-1:0] BIT_ONE = BW'(1);

	// Clock domain of the system clock.
	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic s1_nxt;
	logic s2_nxt;
	logic s3_nxt;
	logic idle_r;
	logic idle_nxt;
	logic [CW-1:0] mono_r;
	logic [CW-1:0] mono_nxt;
	logic [POS_W-1:0] snap_r;
	logic [POS_W-1:0] snap_nxt;
	logic [POS_W-1:0] gray;
	logic fall;

	// Clock domain of the link clock.
	logic link_rst_n;
	logic [BW-1:0] bcnt_r;
	logic [BW-1:0] bcnt_nxt;
	logic [POS_W-1:0] sh_r;
	logic [POS_W-1:0] sh_nxt;
	logic bit_r;
	logic bit_nxt;

	// Gray code of the live position, so only one bit changes per step.
	assign gray = pos ^ (pos >> 1); // see [R13]

	// A falling edge of the link clock, seen after the synchroniser.
	assign fall = s3_r & ~s2_r;

	// Next values of the system clock side.
	// The snapshot follows the position only while the link rests, and freezes as soon as
	// the clock is seen low; the link side reads it only while it is frozen.
	always_comb
	begin
		s1_nxt = link.sclk;
		s2_nxt = s1_r;
		s3_nxt = s2_r;
		idle_nxt = idle_r;
		mono_nxt = mono_r;
		snap_nxt = snap_r;
		if (idle_r)
		begin
			if (s2_r)
			begin
				snap_nxt = gray; // see [R2]
			end
			else
			begin
				idle_nxt = 1'b0; // see [R2]
				mono_nxt = MONO_LD;
			end
		end
		else if (fall)
		begin
			mono_nxt = MONO_LD; // see [R7]
		end
		else if (mono_r == MONO_ONE)
		begin
			mono_nxt = '0;
			idle_nxt = 1'b1; // see [R5]
		end
		else if (mono_r != '0)
		begin
			mono_nxt = mono_r - MONO_ONE;
		end
	end

	// Registers of the system clock side, frozen while the enable is low.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s1_r <= ssi_pkg::LINE_IDLE;
			s2_r <= ssi_pkg::LINE_IDLE;
			s3_r <= ssi_pkg::LINE_IDLE;
			idle_r <= 1'b1;
			mono_r <= '0;
			snap_r <= '0;
		end
		else if (ce)
		begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s3_r <= s3_nxt;
			idle_r <= idle_nxt;
			mono_r <= mono_nxt;
			snap_r <= snap_nxt;
		end
	end

	// The expired monoflop holds the link side in reset, which parks the data line high.
	// The link clock may stop between bursts, so nothing on it could end the frame itself.
	assign link_rst_n = arst_n & ~idle_r; // see [R11]

	// Next values of the shift logic, taken at each rising edge of the link clock.
	// A count of zero loads the frozen snapshot: after the reset this is a fresh word,
	// after the low gap of a finished word it is the same word again.
	always_comb
	begin
		bcnt_nxt = bcnt_r;
		sh_nxt = sh_r;
		bit_nxt = bit_r;
		if (bcnt_r == BIT_LAST)
		begin
			bcnt_nxt = '0;
			bit_nxt = 1'b0; // see [R5]
		end
		else if (bcnt_r == '0)
		begin
			bit_nxt = snap_r[POS_W-1]; // see [R3] [R10]
			sh_nxt = {snap_r[POS_W-2:0], 1'b0};
			bcnt_nxt = BIT_ONE;
		end
		else
		begin
			bit_nxt = sh_r[POS_W-1]; // see [R4]
			sh_nxt = {sh_r[POS_W-2:0], 1'b0};
			bcnt_nxt = bcnt_r + BIT_ONE; // see [R9]
		end
	end

	// Registers of the link side; they change only on rising link clock edges and at the monoflop reset.
	always_ff @(posedge link.sclk or negedge link_rst_n)
	begin
		if (!link_rst_n)
		begin
			bcnt_r <= '0;
			sh_r <= '0;
			bit_r <= ssi_pkg::LINE_IDLE; // see [R1]
		end
		else
		begin
			bcnt_r <= bcnt_nxt;
			sh_r <= sh_nxt;
			bit_r <= bit_nxt;
		end
	end

	// Data line straight from its flip-flop.
	assign link.sdata = bit_r;

	// Busy from the first seen falling edge until the monoflop expires.
	assign busy = ~idle_r;

endmodule : ssi_encoder_end

// [ssi_link_properties.sv]
// Checks on the two link wires: clock widths, burst framing and data timing.
// Assumes both ends share clk and arst_n and their enable drops only while the link rests.
`timescale 1ns/10ps
module ssi_link_properties #(
	parameter int POS_W = ssi_pkg::POS_W,
	parameter int HALF_CYCLES = ssi_pkg::HALF_CYCLES,
	parameter int PAUSE_CYCLES = ssi_pkg::PAUSE_CYCLES,
	parameter int MONO_CYCLES = ssi_pkg::MONO_CYCLES,
	parameter int WORDS = ssi_pkg::REPEAT_WORDS
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic arst_n,
	// Link wires.
	input wire logic sclk,
	input wire logic sdata
);
	localparam logic [9:0] TM_LO = 10'(MONO_CYCLES - HALF_CYCLES);
	logic sclk_r;
	logic [9:0] high_r;
	logic [9:0] high_nxt;
	logic [7:0] rise_r;
	logic [7:0] rise_nxt;

	// High time saturates, so a long pause never wraps to a short one.
	always_comb
	begin
		high_nxt = (high_r == 10'h3ff) ? high_r : high_r + 10'h001;
		if (!sclk)
			high_nxt = 10'h000;
		rise_nxt = rise_r;
		if (!sclk && sclk_r && high_r != 10'(HALF_CYCLES))
			rise_nxt = 8'h00;
		if (sclk && !sclk_r)
			rise_nxt = rise_r + 8'h01;
	end

	// Reset values make the first burst look like one after a long pause.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sclk_r <= 1'b1;
			high_r <= 10'h3ff;
			rise_r <= 8'((POS_W + 1) * WORDS);
		end
		else
		begin
			sclk_r <= sclk;
			high_r <= high_nxt;
			rise_r <= rise_nxt;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	// A fall after more than one half period of high opens a burst.
	sequence s_fall;
		$fell(sclk);
	endsequence
	sequence s_burst_start;
		$fell(sclk) && high_r != 10'(HALF_CYCLES);
	endsequence

	a_idle_high: assert property (high_r >= 10'(MONO_CYCLES + 4) |-> sdata)
		else $error("data not high after timeout");
	a_tail_hold: assert property ($rose(sdata) |-> high_r <= 10'h002 || high_r >= TM_LO)
		else $error("data rose before timeout");
	a_low_stable: assert property (!sclk && !sclk_r |-> $stable(sdata))
		else $error("data moved while clock low");
	a_low_width: assert property (s_fall |-> ##HALF_CYCLES $rose(sclk))
		else $error("clock low time wrong");
	a_high_width: assert property (s_fall |-> high_r >= 10'(HALF_CYCLES))
		else $error("clock high time short");
	a_burst_gap: assert property (s_burst_start |-> sdata || high_r >= 10'(PAUSE_CYCLES))
		else $error("burst began too early");
	a_pulse_count: assert property (s_burst_start |-> rise_r == 8'((POS_W + 1) * WORDS))
		else $error("wrong pulse count in burst");
	a_gap_low: assert property ($fell(sclk) && rise_r == 8'(POS_W + 1) |-> !sdata)
		else $error("gap bit not low");
endmodule : ssi_link_properties

// [tb_ssi_position_transmitter.sv]
// Bench joining both link ends; a queue model predicts every word and wire bit.
// Assumes shortened timeout and pause counts; the enable drops only while the link rests.
`timescale 1ns/10ps
module tb_ssi_position_transmitter;
	localparam int W = ssi_pkg::POS_W;
	localparam int HALF = 10;
	localparam int MONO = 40;
	localparam int PAUSE = 60;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic ce = 1'b1;
	logic start = 1'b0;
	logic [W-1:0] pos = '0;
	logic busy;
	logic ready;
	logic [W-1:0] word;
	logic word_valid;
	logic mismatch;
	int n_mismatch = 0;
	int checks_done = 0;
	int cycles = 0;
	int k = 0;
	int kbase = 0;
	int gexp = 0;
	int exp_q[$];

	ssi_link_if link ();
	ssi_encoder_end #(.MONO_CYCLES(MONO)) ssi_encoder_end_i (.clk(clk), .arst_n(arst_n),
		.ce(ce), .link(link), .pos(pos), .busy(busy));
	ssi_controller_end #(.HALF_CYCLES(HALF), .PAUSE_CYCLES(PAUSE)) ssi_controller_end_i (
		.clk(clk), .arst_n(arst_n), .ce(ce), .link(link), .start(start), .ready(ready),
		.word(word), .word_valid(word_valid), .mismatch(mismatch));
	ssi_link_properties #(.HALF_CYCLES(HALF), .PAUSE_CYCLES(PAUSE), .MONO_CYCLES(MONO))
		ssi_link_properties_i (.clk(clk), .arst_n(arst_n), .sclk(link.sclk),
		.sdata(link.sdata));

	task automatic check(input logic [31:0] seen, input logic [31:0] expv);
		checks_done++;
		if (seen !== expv)
		begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, expv);
		end
	endtask : check

	task automatic conclude;
		if (n_mismatch == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude

	// Gray bit expected after rise kk; the slot after the last bit is the low gap.
	function automatic logic [31:0] wire_bit(input int kk);
		int j;
		j = (kk - 1) % (W + 1);
		return (j < W) ? 32'((gexp >> (W - 1 - j)) & 1) : 32'h0;
	endfunction : wire_bit

	// One burst; a new position and a request mid-burst must not disturb it.
	task automatic burst;
		while (ready !== 1'b1)
			@(posedge clk);
		check(32'(busy), 32'h0); // Idle
		pos <= W'($urandom);
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		repeat (20) @(posedge clk);
		check(32'(busy), 32'h1); // Captured
		check(32'(ready), 32'h0); // Busy
		pos <= W'($urandom);
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
	endtask : burst

	initial
		forever #25 clk = ~clk;

	initial
	begin
		void'($urandom(42123));
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		check(32'(link.sclk), 32'h1); // Idle
		check(32'(link.sdata), 32'h1); // Idle
		repeat (12) burst();
		while (ready !== 1'b1)
			@(posedge clk);
		check(32'(exp_q.size()), 32'h0); // All copies
		// A request while the enable is low must be lost, and the link must stay at rest.
		ce <= 1'b0;
		start <= 1'b1;
		repeat (6) @(posedge clk);
		start <= 1'b0;
		ce <= 1'b1;
		repeat (4) @(posedge clk);
		check(32'(link.sclk), 32'h1); // Frozen
		check(32'(ready), 32'h1); // Frozen
		check(32'(busy), 32'h0); // Frozen
		check(32'(exp_q.size()), 32'h0); // No burst
		conclude();
	end

	// The model queues one expected word per copy at each accepted request.
	always @(posedge clk)
	begin
		if (start === 1'b1 && ready === 1'b1 && ce === 1'b1)
		begin
			kbase = k;
			gexp = int'(pos ^ (pos >> 1));
			repeat (ssi_pkg::REPEAT_WORDS) exp_q.push_back(int'(pos));
		end
		if (word_valid === 1'b1)
		begin
			check(32'(word), exp_q.size() > 0 ? exp_q.pop_front() : -1);
			check(32'(mismatch), 32'h0); // Copies agree
		end
	end

	always @(posedge link.sclk)
		k++;

	// The wire is judged where the controller samples it, on each fall after the first.
	always @(negedge link.sclk)
		if (k > kbase)
			check(32'(link.sdata), wire_bit(k - kbase));

	// Cuts a hang short; twelve bursts need about 12400 cycles.
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			n_mismatch++;
			conclude();
		end
	end
endmodule : tb_ssi_position_transmitter
